// *** verilog/mspw_pkg.sv ***
// Package for the master/slave PWM channel pair.
// Assumes a classic Wishbone slave with 32-bit data and byte addresses.
package mspw_pkg;

  // ----------------------------------------------------------------------
  // Register map (byte offsets).
  // ----------------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL    = 8'h00; // Start/stop triggers, unit on.
  localparam logic [7:0] OFS_STATUS  = 8'h04; // Enable-status bits.
  localparam logic [7:0] OFS_PERIOD  = 8'h08; // Master period data.
  localparam logic [7:0] OFS_DUTY    = 8'h0C; // Slave duty data.
  localparam logic [7:0] OFS_MCOUNT  = 8'h10; // Master counter value.
  localparam logic [7:0] OFS_SCOUNT  = 8'h14; // Slave counter value.
  localparam logic [7:0] OFS_OUTCFG  = 8'h18; // Output enable/level/mode.
  localparam logic [7:0] OFS_MODE    = 8'h1C; // Master and slave mode regs.
  localparam logic [7:0] OFS_PRESCALE = 8'h20; // Count-clock divider.

  // ----------------------------------------------------------------------
  // Field positions.
  // ----------------------------------------------------------------------
  localparam int CTRL_MSTART = 0;
  localparam int CTRL_SSTART = 1;
  localparam int CTRL_MSTOP  = 2;
  localparam int CTRL_SSTOP  = 3;
  localparam int CTRL_UNITON = 4;
  localparam int STAT_MEN    = 0;
  localparam int STAT_SEN    = 1;
  localparam int OCF_OE      = 0; // Slave output enable.
  localparam int OCF_OUTBIT  = 1; // Slave output bit (level in port mode).
  localparam int OCF_LEVEL   = 2; // Slave output level (polarity).
  localparam int OCF_SMODE   = 3; // Slave output mode bit.
  localparam int OCF_MLEVEL  = 4; // Master output level bit.
  localparam int OCF_MMODE   = 5; // Master output mode bit.

  localparam int CNT_W = 16;
  localparam logic [CNT_W-1:0] CNT_ZERO  = 16'h0000;
  localparam logic [CNT_W-1:0] DATA_RST  = 16'h0000;
  localparam logic [15:0]      PSC_RST   = 16'h0000;
  localparam logic [31:0]      MODE_RST  = 32'h0000_0000;

endpackage : mspw_pkg

// *** verilog/mspw_prescaler.sv ***
// Count-clock enable generator for the PWM pair.
// Assumes one clock MCLK; divides by reload plus one when running.
`timescale 1ns/1ps
module mspw_prescaler
  import mspw_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        run,
  input  wire logic [15:0] reload,
  output logic             tick
);

  logic [15:0] cnt_q;
  logic [15:0] cnt_d;
  wire         at_zero = (cnt_q == 16'h0000);

  // ----------------------------------------------------------------------
  // Divider: a zero reload gives a tick every clock.
  // ----------------------------------------------------------------------
  assign cnt_d = !run ? 16'h0000 : (at_zero ? reload : cnt_q - 16'h0001);
  assign tick  = run && at_zero;

  // Counter register.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) cnt_q <= 16'h0000;
    else        cnt_q <= cnt_d;
  end

endmodule : mspw_prescaler

// *** verilog/mspw_counter.sv ***
// One 16-bit down counter used for both master and slave channels.
// Assumes tick is a one-cycle count-clock enable.
`timescale 1ns/1ps
module mspw_counter
  import mspw_pkg::*;
(
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             clr,
  input  wire logic             load,
  input  wire logic             dec,
  input  wire logic [CNT_W-1:0] data,
  output logic      [CNT_W-1:0] value,
  output logic                  is_zero
);

  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;

  // ----------------------------------------------------------------------
  // Clear wins over load, load over decrement; the value holds otherwise.
  // ----------------------------------------------------------------------
  assign cnt_d   = clr ? CNT_ZERO : load ? data
                 : dec ? cnt_q - 16'h0001 : cnt_q;
  assign value   = cnt_q;
  assign is_zero = (cnt_q == CNT_ZERO);

  // Counter register.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) cnt_q <= CNT_ZERO;
    else        cnt_q <= cnt_d;
  end

endmodule : mspw_counter

// *** verilog/mspw_top.sv ***
// Master/slave PWM channel pair with a classic Wishbone register slave.
// Assumes one 20 MHz clock; count clock is a divided enable pulse.
`timescale 1ns/1ps
// Operation
// - Start trigger bits self-clear and always read as zero.
// - Start sets both enable bits; master fires done, starting the slave.
// - Both counter values are readable at any time.
// - Master loads period, counts down, at zero fires done and reloads.
// - Each master done with the slave enabled loads duty into slave counter and starts it.
// - Slave output goes active one count clock after master done.
// - Slave at zero drives output inactive and stops counting.
// - Stop clears both enable bits and halts; counters keep values.
// - Stop leaves the slave output level unchanged.
// - After stop with output disabled, pin follows written output bit.
// - Unit clock off resets all channel state, output bit, port mode.
// - PWM period equals period data plus one count clocks.
// - Slave stays halted at zero until next master done.
// - Output level bit zero is active high, one is active low.
module mspw_top
  import mspw_pkg::*;
(
  input  wire logic        MCLK,
  input  wire logic        ARST_N,
  input  wire logic        WB_CYC_I,
  input  wire logic        WB_STB_I,
  input  wire logic        WB_WE_I,
  input  wire logic [7:0]  WB_ADR_I,
  input  wire logic [3:0]  WB_SEL_I,
  input  wire logic [31:0] WB_DAT_I,
  output logic      [31:0] WB_DAT_O,
  output logic             WB_ACK_O,
  output logic             MASTER_COUNT_DONE_IRQ,
  output logic             SLAVE_COUNT_DONE_IRQ,
  output logic             PWM_OUTPUT,
  output logic             PWM_TIMER_MODE
);

  // ----------------------------------------------------------------------
  // Bus decode.
  // ----------------------------------------------------------------------
  logic        ack_q;
  logic [31:0] rdat_q;
  wire         req      = WB_CYC_I && WB_STB_I && !ack_q;
  wire         wr       = req && WB_WE_I;
  wire         wr_lo    = wr && WB_SEL_I[0];
  wire         wr_hi    = wr && WB_SEL_I[1];
  wire         wr_ctrl  = wr_lo && (WB_ADR_I == OFS_CTRL);
  wire         sel_per  = WB_ADR_I == OFS_PERIOD;
  wire         sel_duty = WB_ADR_I == OFS_DUTY;
  wire         sel_psc  = WB_ADR_I == OFS_PRESCALE;
  wire         wr_ocf   = wr_lo && (WB_ADR_I == OFS_OUTCFG);
  wire         sel_mode = WB_ADR_I == OFS_MODE;

  // ----------------------------------------------------------------------
  // Stored configuration.
  // ----------------------------------------------------------------------
  logic              unit_on_q;
  logic [CNT_W-1:0]  period_q;
  logic [CNT_W-1:0]  duty_q;
  logic [15:0]       psc_q;
  logic [31:0]       mode_q;
  logic              oe_q;
  logic              outbit_q;
  logic              level_q;
  logic              smode_q;
  logic              mlevel_q;
  logic              mmode_q;
  logic              men_q;
  logic              sen_q;
  logic              srun_q;
  logic              pend_q;
  logic              act_q;

  // Trigger pulses; triggers are never stored so they read back zero.
  wire m_start = wr_ctrl && WB_DAT_I[CTRL_MSTART];
  wire s_start = wr_ctrl && WB_DAT_I[CTRL_SSTART];
  wire m_stop  = wr_ctrl && WB_DAT_I[CTRL_MSTOP];
  wire s_stop  = wr_ctrl && WB_DAT_I[CTRL_SSTOP];
  // Unit-off: all channel state is cleared while the unit input is off.
  wire unit_off = !unit_on_q;

  // Stop has priority over a start written in the same access.
  wire m_go = m_start && !m_stop && !men_q;
  wire s_go = s_start && !s_stop;

  // ----------------------------------------------------------------------
  // Count clock and counters.
  // ----------------------------------------------------------------------
  logic             tick;
  logic [CNT_W-1:0] mcnt;
  logic [CNT_W-1:0] scnt;
  logic             mzero;
  logic             szero;
  logic             mstart_q;

  mspw_prescaler u_psc (
    .clk    (MCLK),
    .rst_n  (ARST_N),
    .run    (men_q),
    .reload (psc_q),
    .tick   (tick)
  );

  // The master loads on the first tick after start, else reloads at zero.
  wire m_fire = men_q && tick && (mstart_q || mzero);
  wire m_load = m_fire;
  wire m_dec  = men_q && tick && !m_fire;
  // Master done coincides with its load, so the start fires it too.
  assign MASTER_COUNT_DONE_IRQ = m_fire;

  mspw_counter u_mcnt (
    .clk     (MCLK),
    .rst_n   (ARST_N),
    .clr     (unit_off),
    .load    (m_load),
    .dec     (m_dec),
    .data    (period_q),
    .value   (mcnt),
    .is_zero (mzero)
  );

  // Slave loads duty on master done, counts until zero, then idles.
  wire s_load   = sen_q && m_fire;
  wire s_dec    = sen_q && srun_q && tick && !m_fire && !szero;
  wire s_end    = sen_q && srun_q && tick && !m_fire && szero;
  assign SLAVE_COUNT_DONE_IRQ = s_end;

  mspw_counter u_scnt (
    .clk     (MCLK),
    .rst_n   (ARST_N),
    .clr     (unit_off),
    .load    (s_load),
    .dec     (s_dec),
    .data    (duty_q),
    .value   (scnt),
    .is_zero (szero)
  );

  // ----------------------------------------------------------------------
  // Channel enables and sequencing flags.
  // ----------------------------------------------------------------------
  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      men_q    <= 1'b0;
      sen_q    <= 1'b0;
      mstart_q <= 1'b0;
    end else if (unit_off) begin
      men_q    <= 1'b0;
      sen_q    <= 1'b0;
      mstart_q <= 1'b0;
    end else begin
      if (m_stop) men_q <= 1'b0;
      else if (m_go) men_q <= 1'b1;
      if (s_stop) sen_q <= 1'b0;
      else if (s_go) sen_q <= 1'b1;
      if (m_go) mstart_q <= 1'b1;
      else if (m_fire || m_stop) mstart_q <= 1'b0;
    end
  end

  // Slave run flag: halted after zero until the next master done.
  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N)              srun_q <= 1'b0;
    else if (unit_off)        srun_q <= 1'b0;
    else if (s_load)          srun_q <= 1'b1;
    else if (s_end || s_stop) srun_q <= 1'b0;
  end

  // ----------------------------------------------------------------------
  // Output: active one count clock after master done, inactive at zero.
  // Pend marks the load tick so the edge appears at the following tick.
  // ----------------------------------------------------------------------
  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      pend_q <= 1'b0;
      act_q  <= 1'b0;
    end else if (unit_off) begin
      pend_q <= 1'b0;
      act_q  <= 1'b0;
    end else if (sen_q && oe_q && tick) begin
      pend_q <= m_fire;
      if (pend_q && !szero) act_q <= 1'b1;
      else if (s_end || (pend_q && szero)) act_q <= 1'b0;
    end
    // With the channel stopped, act_q holds its level.
  end

  // Polarity, and port-level output when output enable is cleared.
  wire counting_level = act_q ^ level_q;
  wire pin_level      = oe_q ? counting_level : outbit_q;

  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) PWM_OUTPUT <= 1'b0;
    else         PWM_OUTPUT <= pin_level;
  end
  // Timer mode on the pin; low means the pin is back in port mode.
  assign PWM_TIMER_MODE = unit_on_q;

  // ----------------------------------------------------------------------
  // Register writes. Software keeps modes fixed and rewrites data only
  // after master done; hardware does not block such writes.
  // ----------------------------------------------------------------------
  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      unit_on_q <= 1'b0;
    end else if (wr_ctrl) begin
      unit_on_q <= WB_DAT_I[CTRL_UNITON];
    end
  end

  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      period_q <= DATA_RST;
      duty_q   <= DATA_RST;
      psc_q    <= PSC_RST;
      mode_q   <= MODE_RST;
    end else if (unit_off) begin
      period_q <= DATA_RST;
      duty_q   <= DATA_RST;
      psc_q    <= PSC_RST;
      mode_q   <= MODE_RST;
    end else begin
      if (wr_lo && sel_per)  period_q[7:0]  <= WB_DAT_I[7:0];
      if (wr_hi && sel_per)  period_q[15:8] <= WB_DAT_I[15:8];
      if (wr_lo && sel_duty) duty_q[7:0]    <= WB_DAT_I[7:0];
      if (wr_hi && sel_duty) duty_q[15:8]   <= WB_DAT_I[15:8];
      if (wr_lo && sel_psc)  psc_q[7:0]     <= WB_DAT_I[7:0];
      if (wr_hi && sel_psc)  psc_q[15:8]    <= WB_DAT_I[15:8];
      if (wr_lo && sel_mode) mode_q[7:0]    <= WB_DAT_I[7:0];
      if (wr_hi && sel_mode) mode_q[15:8]   <= WB_DAT_I[15:8];
      if (wr && WB_SEL_I[2] && sel_mode) mode_q[23:16] <= WB_DAT_I[23:16];
      if (wr && WB_SEL_I[3] && sel_mode) mode_q[31:24] <= WB_DAT_I[31:24];
    end
  end

  // Output configuration; unit-off clears the output bit to zero.
  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      {oe_q, outbit_q, level_q, smode_q, mlevel_q, mmode_q} <= 6'h00;
    end else if (unit_off) begin
      {oe_q, outbit_q, level_q, smode_q, mlevel_q, mmode_q} <= 6'h00;
    end else if (wr_ocf) begin
      oe_q     <= WB_DAT_I[OCF_OE];
      outbit_q <= WB_DAT_I[OCF_OUTBIT];
      level_q  <= WB_DAT_I[OCF_LEVEL];
      smode_q  <= WB_DAT_I[OCF_SMODE];
      mlevel_q <= WB_DAT_I[OCF_MLEVEL];
      mmode_q  <= WB_DAT_I[OCF_MMODE];
    end
  end

  // ----------------------------------------------------------------------
  // Read mux; counters are live at every read.
  // ----------------------------------------------------------------------
  logic [31:0] rmux;
  always_comb begin
    rmux = 32'h0000_0000;
    case (WB_ADR_I)
      OFS_CTRL:     rmux[CTRL_UNITON] = unit_on_q;
      OFS_STATUS:   rmux[STAT_SEN:STAT_MEN] = {sen_q, men_q};
      OFS_PERIOD:   rmux[15:0] = period_q;
      OFS_DUTY:     rmux[15:0] = duty_q;
      OFS_MCOUNT:   rmux[15:0] = mcnt;
      OFS_SCOUNT:   rmux[15:0] = scnt;
      OFS_OUTCFG:   rmux[5:0]  = {mmode_q, mlevel_q, smode_q,
                                  level_q, outbit_q, oe_q};
      OFS_MODE:     rmux = mode_q;
      OFS_PRESCALE: rmux[15:0] = psc_q;
      default:      rmux = 32'h0000_0000;
    endcase
  end

  // One-wait-state ack; unmapped addresses ack and read zero.
  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      ack_q  <= 1'b0;
      rdat_q <= 32'h0000_0000;
    end else begin
      ack_q  <= req;
      rdat_q <= rmux;
    end
  end
  assign WB_ACK_O = ack_q;
  assign WB_DAT_O = rdat_q;

  // ----------------------------------------------------------------------
  // Checks.
  // ----------------------------------------------------------------------
  sequence s_done_edge;
    m_fire && sen_q && oe_q && !m_stop;
  endsequence

  a_ctrl_reads_zero: assert property (@(posedge MCLK)
    disable iff (!ARST_N)
    WB_ACK_O && !WB_WE_I && (WB_ADR_I == OFS_CTRL) |->
      WB_DAT_O[CTRL_SSTOP:CTRL_MSTART] == 4'h0)
    else $error("trigger bits read back nonzero");
  a_start_enables: assert property (@(posedge MCLK)
    disable iff (!ARST_N)
    m_go && s_go && unit_on_q |=> men_q && sen_q)
    else $error("start did not set enable bits");
  // The divider idles at zero, so the first tick and done follow start.
  a_first_done: assert property (@(posedge MCLK)
    disable iff (!ARST_N)
    m_go && !unit_off |=> MASTER_COUNT_DONE_IRQ)
    else $error("master did not signal done as it started");
  a_stop_wins: assert property (@(posedge MCLK)
    disable iff (!ARST_N)
    m_stop |=> !men_q)
    else $error("master enabled after stop");
  a_stop_clears_en: assert property (@(posedge MCLK)
    disable iff (!ARST_N)
    m_stop && s_stop |=> !men_q && !sen_q)
    else $error("stop did not clear enable bits");
  a_stop_holds_cnt: assert property (@(posedge MCLK)
    disable iff (!ARST_N)
    !men_q && !m_load && !unit_off |=> $stable(mcnt))
    else $error("master counter moved while stopped");
  a_reload_period: assert property (@(posedge MCLK)
    disable iff (!ARST_N)
    m_fire && !unit_off |=> mcnt == $past(period_q))
    else $error("master did not reload period");
  a_slave_load: assert property (@(posedge MCLK)
    disable iff (!ARST_N)
    s_load && !unit_off |=> scnt == $past(duty_q) && srun_q)
    else $error("slave did not load duty");
  a_slave_halt: assert property (@(posedge MCLK)
    disable iff (!ARST_N)
    s_end && !unit_off |=> !srun_q ##0 $stable(scnt))
    else $error("slave kept running after zero");
  a_out_inactive: assert property (@(posedge MCLK)
    disable iff (!ARST_N)
    s_end && oe_q && !unit_off |=> !act_q)
    else $error("output stayed active at zero");
  a_stop_keeps_out: assert property (@(posedge MCLK)
    disable iff (!ARST_N)
    !sen_q && $past(!sen_q) && oe_q && !unit_off |=> $stable(act_q))
    else $error("output changed while stopped");
  a_port_level: assert property (@(posedge MCLK)
    disable iff (!ARST_N)
    !oe_q |=> PWM_OUTPUT == $past(outbit_q))
    else $error("pin did not follow the written output bit");
  a_unit_off_clear: assert property (@(posedge MCLK)
    disable iff (!ARST_N)
    unit_off |=> !outbit_q && !men_q && mcnt == CNT_ZERO &&
      PWM_TIMER_MODE == $past(wr_ctrl && WB_DAT_I[CTRL_UNITON]))
    else $error("unit off did not clear state");
  a_active_next: assert property (@(posedge MCLK)
    disable iff (!ARST_N)
    s_done_edge ##1 (tick && pend_q && !szero && !unit_off && sen_q && oe_q)
      |=> act_q)
    else $error("output not active one count clock after done");

endmodule : mspw_top

// *** tb/tb_mspw_top.sv ***
// Self-checking bench for the master/slave PWM channel pair.
// Assumes the design package is compiled first; drives the Wishbone side.
`timescale 1ns/1ps
module tb_mspw_top;
  import mspw_pkg::*;

  // ------------------------------------------------------------------
  // Signals and counters.
  // ------------------------------------------------------------------
  logic        MCLK;
  logic        ARST_N;
  logic        WB_CYC_I;
  logic        WB_STB_I;
  logic        WB_WE_I;
  logic [7:0]  WB_ADR_I;
  logic [3:0]  WB_SEL_I;
  logic [31:0] WB_DAT_I;
  logic [31:0] WB_DAT_O;
  logic        WB_ACK_O;
  logic        MASTER_COUNT_DONE_IRQ;
  logic        SLAVE_COUNT_DONE_IRQ;
  logic        PWM_OUTPUT;
  logic        PWM_TIMER_MODE;
  int          n_fail;
  int          cmp_count;
  int          cyc_n;
  int          per;
  int          hi;
  int          sdone;
  logic [31:0] rd;
  logic [31:0] held;

  mspw_top u_dut (
    .MCLK                  (MCLK),
    .ARST_N                (ARST_N),
    .WB_CYC_I              (WB_CYC_I),
    .WB_STB_I              (WB_STB_I),
    .WB_WE_I               (WB_WE_I),
    .WB_ADR_I              (WB_ADR_I),
    .WB_SEL_I              (WB_SEL_I),
    .WB_DAT_I              (WB_DAT_I),
    .WB_DAT_O              (WB_DAT_O),
    .WB_ACK_O              (WB_ACK_O),
    .MASTER_COUNT_DONE_IRQ (MASTER_COUNT_DONE_IRQ),
    .SLAVE_COUNT_DONE_IRQ  (SLAVE_COUNT_DONE_IRQ),
    .PWM_OUTPUT            (PWM_OUTPUT),
    .PWM_TIMER_MODE        (PWM_TIMER_MODE)
  );

  // 50 ns period; the watchdog cuts a hung handshake short.
  initial MCLK = 1'b0;
  always #25 MCLK = ~MCLK;
  always @(posedge MCLK) begin
    cyc_n++;
    if (cyc_n >= 20000) begin
      n_fail++;
      stop_test();
    end
  end

  // ------------------------------------------------------------------
  // Bus, compare and measurement tasks.
  // ------------------------------------------------------------------
  // One classic cycle; read data is taken at the edge that sees ack.
  task automatic wb(input logic we, input logic [7:0] adr,
                    input logic [31:0] dat);
    @(posedge MCLK);
    WB_CYC_I <= 1'b1;
    WB_STB_I <= 1'b1;
    WB_WE_I  <= we;
    WB_ADR_I <= adr;
    WB_SEL_I <= 4'hF;
    WB_DAT_I <= dat;
    do @(posedge MCLK); while (WB_ACK_O !== 1'b1);
    rd = WB_DAT_O;
    WB_CYC_I <= 1'b0;
    WB_STB_I <= 1'b0;
    WB_WE_I  <= 1'b0;
  endtask : wb

  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
      n_fail++;
    end
  endtask : chk

  task automatic rdchk(input logic [7:0] adr, input logic [31:0] exp,
                       input string what);
    wb(1'b0, adr, 32'h0000_0000);
    chk(what, exp, rd);
  endtask : rdchk

  // Counts cycles, pin-high cycles and slave completions between two
  // master completions, so the pin lag of one clock cancels out.
  task automatic measure(output int p, output int h, output int s);
    int k;
    k = 0;
    do begin
      @(posedge MCLK);
      k++;
    end while (MASTER_COUNT_DONE_IRQ !== 1'b1 && k < 1000);
    p = 0;
    h = 0;
    s = 0;
    do begin
      @(posedge MCLK);
      p++;
      h += (PWM_OUTPUT === 1'b1);
      s += (SLAVE_COUNT_DONE_IRQ === 1'b1);
    end while (MASTER_COUNT_DONE_IRQ !== 1'b1 && p < 1000);
  endtask : measure

  task automatic stop_test();
    if (n_fail == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : stop_test

  // ------------------------------------------------------------------
  // Main sequence.
  // ------------------------------------------------------------------
  initial begin
    {ARST_N, WB_CYC_I, WB_STB_I, WB_WE_I} = 4'h0;
    WB_ADR_I = 8'h00;
    WB_SEL_I = 4'h0;
    WB_DAT_I = 32'h0000_0000;
    n_fail = 0;
    cmp_count = 0;
    cyc_n = 0;
    repeat (16) @(posedge MCLK);
    ARST_N <= 1'b1;
    rdchk(OFS_STATUS, 32'h0000_0000, "status_reset");
    // Unit on first, since writes are discarded while it is off.
    wb(1'b1, OFS_CTRL, 32'h0000_0010);
    wb(1'b1, OFS_MODE, 32'hA5C3_0F81);
    rdchk(OFS_MODE, 32'hA5C3_0F81, "mode_reg");
    wb(1'b1, OFS_PERIOD, 32'h0000_0004);
    wb(1'b1, OFS_DUTY, 32'h0000_0003);
    wb(1'b1, OFS_OUTCFG, 32'h0000_0009);
    wb(1'b1, OFS_CTRL, 32'h0000_0013);
    rdchk(OFS_CTRL, 32'h0000_0010, "ctrl_triggers");
    rdchk(OFS_STATUS, 32'h0000_0003, "status_run");
    chk("timer_mode", 32'h1, {31'h0, PWM_TIMER_MODE});
    measure(per, hi, sdone);
    chk("period", 32'd5, 32'(per));
    chk("high_time", 32'd3, 32'(hi));
    chk("slave_done", 32'd1, 32'(sdone));
    wb(1'b0, OFS_MCOUNT, 32'h0000_0000);
    chk("mcount_range", 32'h1, {31'h0, rd <= 32'd4});
    // Two reads three cycles apart must see a live, moving counter.
    held = rd;
    wb(1'b0, OFS_MCOUNT, 32'h0000_0000);
    chk("mcount_moves", 32'h1, {31'h0, rd != held});
    wb(1'b0, OFS_SCOUNT, 32'h0000_0000);
    chk("scount_range", 32'h1, {31'h0, rd <= 32'd3});
    // Duty is rewritten just after a master completion, as allowed.
    measure(per, hi, sdone);
    wb(1'b1, OFS_DUTY, 32'h0000_0001);
    measure(per, hi, sdone);
    chk("high_new_duty", 32'd1, 32'(hi));
    // Stop: status clears, counters and pin level are frozen.
    wb(1'b1, OFS_CTRL, 32'h0000_001C);
    @(posedge MCLK);
    held = {31'h0, PWM_OUTPUT};
    rdchk(OFS_STATUS, 32'h0000_0000, "status_stop");
    rdchk(OFS_CTRL, 32'h0000_0010, "ctrl_stop_bits");
    wb(1'b0, OFS_MCOUNT, 32'h0000_0000);
    per = int'(rd);
    repeat (20) @(posedge MCLK);
    rdchk(OFS_MCOUNT, 32'(per), "mcount_held");
    chk("pin_held", held, {31'h0, PWM_OUTPUT});
    // Start and stop together must leave the pair stopped.
    wb(1'b1, OFS_CTRL, 32'h0000_001F);
    rdchk(OFS_STATUS, 32'h0000_0000, "status_both");
    // Output disabled: the pin follows the written output bit.
    wb(1'b1, OFS_OUTCFG, 32'h0000_000A);
    repeat (2) @(posedge MCLK);
    chk("pin_port_one", 32'h1, {31'h0, PWM_OUTPUT});
    wb(1'b1, OFS_OUTCFG, 32'h0000_0008);
    repeat (2) @(posedge MCLK);
    chk("pin_port_zero", 32'h0, {31'h0, PWM_OUTPUT});
    // Active-low output with a count clock of MCLK over two.
    wb(1'b1, OFS_PRESCALE, 32'h0000_0001);
    wb(1'b1, OFS_DUTY, 32'h0000_0003);
    wb(1'b1, OFS_OUTCFG, 32'h0000_000D);
    wb(1'b1, OFS_CTRL, 32'h0000_0013);
    measure(per, hi, sdone);
    chk("period_div2", 32'd10, 32'(per));
    chk("high_inverted", 32'd4, 32'(hi));
    // Unit off clears everything and returns the pin to port mode.
    wb(1'b1, OFS_CTRL, 32'h0000_0000);
    repeat (2) @(posedge MCLK);
    chk("mode_off", 32'h0, {31'h0, PWM_TIMER_MODE});
    chk("pin_off", 32'h0, {31'h0, PWM_OUTPUT});
    rdchk(OFS_PERIOD, 32'h0000_0000, "period_off");
    rdchk(OFS_OUTCFG, 32'h0000_0000, "outcfg_off");
    rdchk(OFS_STATUS, 32'h0000_0000, "status_off");
    rdchk(OFS_MODE, 32'h0000_0000, "mode_off");
    rdchk(8'h40, 32'h0000_0000, "unmapped");
    stop_test();
  end

endmodule : tb_mspw_top
